// ---- pie_regs.svh ----
// Constants of the peripheral interrupt expander: vectors, flag bit positions, codes.
// Assumes a single 100 MHz clock domain and a CPU that acknowledges by source code.
// Overview of operation
// - Reset from pin or watchdog vectors to zero
// - Software NMI, priority three, unmasked, vector 0024h
// - Power fault: line one, bit 0.0, code 0020h
// - External pins: line one, bits 0.2/0.3
// - Converter done: line one, bit 0.1, code 0004h
// - Serial receive high mode: bit 0.5, 0006h
// - Serial transmit high mode: bit 0.6, 0007h
// - Serial receive low mode: line five, bit 1.8
// - Serial transmit low mode: line five, bit 1.9
// - Timer A period: line two, bit 0.12, 0027h
// - Timer A compare/underflow/overflow: bits 0.13-0.15
// - Timer B period: line three, bit 1.0, 002Bh
// - Timer B compare/underflow/overflow: bits 1.1-1.3
// - Each source routed to exactly one core line
// - Gated by source enable and core line mask
`ifndef PIE_REGS_SVH
`define PIE_REGS_SVH

`define PIE_VEC_RESET       16'h0000
`define PIE_VEC_NMI         16'h0024
`define PIE_VEC_LINE1       16'h0002
`define PIE_VEC_LINE2       16'h0004
`define PIE_VEC_LINE3       16'h0006
`define PIE_VEC_LINE5       16'h000A
`define PIE_NMI_PRIORITY    6'h03
`define PIE_CODE_NONE       16'h0000

// Flag bit positions: group 0 in bits 15:0, group 1 in bits 31:16
`define PIE_BIT_FAULT       0
`define PIE_BIT_CONV        1
`define PIE_BIT_EXTA        2
`define PIE_BIT_EXTB        3
`define PIE_BIT_RX_HI       5
`define PIE_BIT_TX_HI       6
`define PIE_BIT_TA_PER      12
`define PIE_BIT_TA_CMP      13
`define PIE_BIT_TA_UF       14
`define PIE_BIT_TA_OF       15
`define PIE_BIT_TB_PER      16
`define PIE_BIT_TB_CMP      17
`define PIE_BIT_TB_UF       18
`define PIE_BIT_TB_OF       19
`define PIE_BIT_RX_LO       24
`define PIE_BIT_TX_LO       25

`define PIE_CODE_FAULT      16'h0020
`define PIE_CODE_CONV       16'h0004
`define PIE_CODE_EXTA       16'h0001
`define PIE_CODE_EXTB       16'h0011
`define PIE_CODE_RX         16'h0006
`define PIE_CODE_TX         16'h0007
`define PIE_CODE_TA_PER     16'h0027
`define PIE_CODE_TA_CMP     16'h0028
`define PIE_CODE_TA_UF      16'h0029
`define PIE_CODE_TA_OF      16'h002A
`define PIE_CODE_TB_PER     16'h002B
`define PIE_CODE_TB_CMP     16'h002C
`define PIE_CODE_TB_UF      16'h002D
`define PIE_CODE_TB_OF      16'h002E

// Overall priority numbers; a smaller number is served first
`define PIE_PRIO_FAULT      6'h04
`define PIE_PRIO_CONV       6'h06
`define PIE_PRIO_EXTA       6'h07
`define PIE_PRIO_EXTB       6'h08
`define PIE_PRIO_RX_HI      6'h0A
`define PIE_PRIO_TX_HI      6'h0B
`define PIE_PRIO_TA_PER     6'h11
`define PIE_PRIO_TA_CMP     6'h12
`define PIE_PRIO_TA_UF      6'h13
`define PIE_PRIO_TA_OF      6'h14
`define PIE_PRIO_TB_PER     6'h1C
`define PIE_PRIO_TB_CMP     6'h1D
`define PIE_PRIO_TB_UF      6'h1E
`define PIE_PRIO_TB_OF      6'h1F
`define PIE_PRIO_RX_LO      6'h2B
`define PIE_PRIO_TX_LO      6'h2C
`define PIE_PRIO_NONE       6'h3F

`endif

// ---- pie_pkg.sv ----
// Types of the peripheral interrupt expander.
// Assumes pie_regs.svh supplies the numeric constants.
package pie_pkg;
  typedef struct packed {
    logic [31:0] pending;
    logic [2:0]  sync_a;
    logic [2:0]  sync_b;
    logic [2:0]  sync_f;
    logic        ext_a_q;
    logic        ext_b_q;
    logic        fault_q;
    logic [5:0]  line;
    logic [15:0] code;
    logic        code_valid;
    logic        nmi;
  } pie_state_t;
endpackage : pie_pkg

// ---- pie_expander.sv ----
// Peripheral interrupt expander: gathers source requests into core interrupt lines.
// Assumes internal sources are one-cycle pulses on i_sys_clk; pins are asynchronous.
`timescale 1ns/10ps
`include "pie_regs.svh"
module pie_expander (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  // Reset sources
  input  wire logic        i_reset_pin_b,
  input  wire logic        i_watchdog_timeout,
  // External pins (asynchronous)
  input  wire logic        i_power_stage_fault_request,
  input  wire logic        i_external_pin_request_a,
  input  wire logic        i_external_pin_request_b,
  // On-chip sources (pulses)
  input  wire logic        i_converter_done_request,
  input  wire logic        i_serial_receive_request,
  input  wire logic        i_serial_transmit_request,
  input  wire logic        i_timer_a_period_request,
  input  wire logic        i_timer_a_compare_request,
  input  wire logic        i_timer_a_underflow_request,
  input  wire logic        i_timer_a_overflow_request,
  input  wire logic        i_timer_b_period_request,
  input  wire logic        i_timer_b_compare_request,
  input  wire logic        i_timer_b_underflow_request,
  input  wire logic        i_timer_b_overflow_request,
  input  wire logic        i_software_nmi,
  // Configuration and acknowledge
  input  wire logic [31:0] i_source_enable,
  input  wire logic [5:0]  i_core_line_mask,
  input  wire logic        i_serial_low_priority,
  input  wire logic [2:0]  i_ack_line,
  input  wire logic        i_ack_valid,
  // Core side
  output logic             o_reset_vector_line,
  output logic [5:0]       o_core_lines,
  output logic             o_nmi,
  output logic [15:0]      o_source_vector_code,
  output logic             o_code_valid,
  output logic [31:0]      o_group_pending_flags,
  output logic [31:0]      o_group_acknowledge_flags
);

  pie_pkg::pie_state_t state_reg;
  pie_pkg::pie_state_t state_next;
  logic [31:0]         set_vec;
  logic [31:0]         ack_vec;
  logic [31:0]         eligible;
  logic [5:0]          best_prio;

  // Code of a flag position; same table feeds vector and acknowledge decode
  function automatic logic [15:0] pie_code(input logic [4:0] pos);
    case (pos)
      5'h00:   pie_code = `PIE_CODE_FAULT;
      5'h01:   pie_code = `PIE_CODE_CONV;
      5'h02:   pie_code = `PIE_CODE_EXTA;
      5'h03:   pie_code = `PIE_CODE_EXTB;
      5'h05:   pie_code = `PIE_CODE_RX;
      5'h06:   pie_code = `PIE_CODE_TX;
      5'h0C:   pie_code = `PIE_CODE_TA_PER;
      5'h0D:   pie_code = `PIE_CODE_TA_CMP;
      5'h0E:   pie_code = `PIE_CODE_TA_UF;
      5'h0F:   pie_code = `PIE_CODE_TA_OF;
      5'h10:   pie_code = `PIE_CODE_TB_PER;
      5'h11:   pie_code = `PIE_CODE_TB_CMP;
      5'h12:   pie_code = `PIE_CODE_TB_UF;
      5'h13:   pie_code = `PIE_CODE_TB_OF;
      5'h18:   pie_code = `PIE_CODE_RX;
      5'h19:   pie_code = `PIE_CODE_TX;
      default: pie_code = `PIE_CODE_NONE;
    endcase
  endfunction : pie_code

  // Core line index (0..5) of a flag position; each bit has exactly one line
  function automatic logic [2:0] pie_line(input logic [4:0] pos);
    if (pos < 5'h0C) begin
      pie_line = 3'h0;
    end else if (pos < 5'h10) begin
      pie_line = 3'h1;
    end else if (pos < 5'h18) begin
      pie_line = 3'h2;
    end else begin
      pie_line = 3'h4;
    end
  endfunction : pie_line

  // Overall priority number of a flag position; unused positions never win
  function automatic logic [5:0] pie_priority(input logic [4:0] pos);
    case (pos)
      5'h00:   pie_priority = `PIE_PRIO_FAULT;
      5'h01:   pie_priority = `PIE_PRIO_CONV;
      5'h02:   pie_priority = `PIE_PRIO_EXTA;
      5'h03:   pie_priority = `PIE_PRIO_EXTB;
      5'h05:   pie_priority = `PIE_PRIO_RX_HI;
      5'h06:   pie_priority = `PIE_PRIO_TX_HI;
      5'h0C:   pie_priority = `PIE_PRIO_TA_PER;
      5'h0D:   pie_priority = `PIE_PRIO_TA_CMP;
      5'h0E:   pie_priority = `PIE_PRIO_TA_UF;
      5'h0F:   pie_priority = `PIE_PRIO_TA_OF;
      5'h10:   pie_priority = `PIE_PRIO_TB_PER;
      5'h11:   pie_priority = `PIE_PRIO_TB_CMP;
      5'h12:   pie_priority = `PIE_PRIO_TB_UF;
      5'h13:   pie_priority = `PIE_PRIO_TB_OF;
      5'h18:   pie_priority = `PIE_PRIO_RX_LO;
      5'h19:   pie_priority = `PIE_PRIO_TX_LO;
      default: pie_priority = `PIE_PRIO_NONE;
    endcase
  endfunction : pie_priority

  always_comb begin
    state_next = state_reg;
    set_vec    = 32'h0000_0000;
    ack_vec    = 32'h0000_0000;
    eligible   = 32'h0000_0000;
    best_prio  = `PIE_PRIO_NONE;

    // Three-stage pin synchronisers; edge counts once stages two and three agree
    state_next.sync_a = {state_reg.sync_a[1:0], i_external_pin_request_a};
    state_next.sync_b = {state_reg.sync_b[1:0], i_external_pin_request_b};
    state_next.sync_f = {state_reg.sync_f[1:0], i_power_stage_fault_request};
    if (state_reg.sync_a[2] == state_reg.sync_a[1]) begin
      state_next.ext_a_q = state_reg.sync_a[2];
    end
    if (state_reg.sync_b[2] == state_reg.sync_b[1]) begin
      state_next.ext_b_q = state_reg.sync_b[2];
    end
    if (state_reg.sync_f[2] == state_reg.sync_f[1]) begin
      state_next.fault_q = state_reg.sync_f[2];
    end

    // Rising edges of the settled pins request service
    set_vec[`PIE_BIT_FAULT] = state_next.fault_q & ~state_reg.fault_q;
    set_vec[`PIE_BIT_EXTA]  = state_next.ext_a_q & ~state_reg.ext_a_q;
    set_vec[`PIE_BIT_EXTB]  = state_next.ext_b_q & ~state_reg.ext_b_q;
    set_vec[`PIE_BIT_CONV]  = i_converter_done_request;
    // Serial mode steers the request to one of two flag bits
    set_vec[`PIE_BIT_RX_HI] = i_serial_receive_request & ~i_serial_low_priority;
    set_vec[`PIE_BIT_TX_HI] = i_serial_transmit_request & ~i_serial_low_priority;
    set_vec[`PIE_BIT_RX_LO] = i_serial_receive_request & i_serial_low_priority;
    set_vec[`PIE_BIT_TX_LO] = i_serial_transmit_request & i_serial_low_priority;
    set_vec[`PIE_BIT_TA_PER] = i_timer_a_period_request;
    set_vec[`PIE_BIT_TA_CMP] = i_timer_a_compare_request;
    set_vec[`PIE_BIT_TA_UF]  = i_timer_a_underflow_request;
    set_vec[`PIE_BIT_TA_OF]  = i_timer_a_overflow_request;
    set_vec[`PIE_BIT_TB_PER] = i_timer_b_period_request;
    set_vec[`PIE_BIT_TB_CMP] = i_timer_b_compare_request;
    set_vec[`PIE_BIT_TB_UF]  = i_timer_b_underflow_request;
    set_vec[`PIE_BIT_TB_OF]  = i_timer_b_overflow_request;
    // A disabled source never latches
    set_vec = set_vec & i_source_enable;

    // Acknowledge clears the bit whose code is presented on that line
    state_next.code       = `PIE_CODE_NONE;
    state_next.code_valid = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (state_reg.pending[i] && i_ack_valid && (pie_line(5'(i)) == i_ack_line)
          && (pie_code(5'(i)) == state_reg.code) && state_reg.code_valid) begin
        ack_vec[i] = 1'b1;
      end
    end
    // Set wins over clear so a coincident event is not lost
    state_next.pending = (state_reg.pending & ~ack_vec) | set_vec;

    // Line outputs gated by the core mask
    state_next.line = 6'h00;
    for (int i = 0; i < 32; i++) begin
      eligible[i] = state_next.pending[i] & i_core_line_mask[pie_line(5'(i))];
      if (eligible[i]) begin
        state_next.line[pie_line(5'(i))] = 1'b1;
      end
    end

    // Smallest overall priority number among masked-in flags presents its code;
    // picked by number, not by bit order, so a remapped table stays correct
    for (int i = 0; i < 32; i++) begin
      if (eligible[i] && (pie_priority(5'(i)) < best_prio)) begin
        best_prio             = pie_priority(5'(i));
        state_next.code       = pie_code(5'(i));
        state_next.code_valid = 1'b1;
      end
    end

    // NMI ignores every mask
    state_next.nmi = i_software_nmi;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reset from pin or watchdog outranks everything and points at address zero
  assign o_reset_vector_line       = ~i_rst_b | ~i_reset_pin_b | i_watchdog_timeout;
  assign o_core_lines              = state_reg.line;
  assign o_nmi                     = state_reg.nmi;
  assign o_source_vector_code      = state_reg.code;
  assign o_code_valid              = state_reg.code_valid;
  assign o_group_pending_flags     = state_reg.pending;
  assign o_group_acknowledge_flags = state_reg.pending & i_source_enable;

endmodule : pie_expander

// ---- pie_expander_monitor.sv ----
// Concurrent checks on the interrupt expander ports.
// Assumes binding to pie_expander; one clock domain.
`timescale 1ns/10ps
module pie_expander_monitor (
  // Clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  // Stimulus seen at the block
  input wire logic        i_reset_pin_b,
  input wire logic        i_watchdog_timeout,
  input wire logic        i_software_nmi,
  input wire logic        i_timer_a_period_request,
  input wire logic        i_serial_receive_request,
  input wire logic        i_serial_low_priority,
  input wire logic        i_ack_valid,
  input wire logic [31:0] i_source_enable,
  input wire logic [5:0]  i_core_line_mask,
  input wire logic [2:0]  i_ack_line,
  // Block outputs
  input wire logic        o_reset_vector_line,
  input wire logic        o_nmi,
  input wire logic        o_code_valid,
  input wire logic [5:0]  o_core_lines,
  input wire logic [15:0] o_source_vector_code,
  input wire logic [31:0] o_group_pending_flags
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_ta_set;
    i_timer_a_period_request && i_source_enable[12];
  endsequence
  sequence s_ta_ack;
    i_ack_valid && i_ack_line == 3'h1 && o_code_valid && o_source_vector_code == 16'h0027
      && !i_timer_a_period_request;
  endsequence
  property p_rst; !i_reset_pin_b || i_watchdog_timeout |-> o_reset_vector_line; endproperty
  property p_nmi; i_software_nmi |=> o_nmi; endproperty
  property p_ta_set; s_ta_set |=> o_group_pending_flags[12]; endproperty
  property p_ta_hold; o_group_pending_flags[12] && !i_ack_valid |=> o_group_pending_flags[12];
  endproperty
  property p_ta_ack; s_ta_ack |=> !o_group_pending_flags[12]; endproperty
  property p_line2; o_core_lines[1] |-> |o_group_pending_flags[15:12]; endproperty
  property p_mask3; !i_core_line_mask[2] ##1 !i_core_line_mask[2] |-> !o_core_lines[2];
  endproperty
  property p_rx_low;
    i_serial_low_priority && i_serial_receive_request && i_source_enable[24]
      |=> o_group_pending_flags[24] && !o_group_pending_flags[5];
  endproperty
  property p_fault; o_code_valid && o_source_vector_code == 16'h0020 |-> o_group_pending_flags[0];
  endproperty
  a_rst: assert property (p_rst) else $error("reset vector line low during reset");
  a_nmi: assert property (p_nmi) else $error("nmi not raised");
  a_ta_set: assert property (p_ta_set) else $error("timer a period not pending");
  a_ta_hold: assert property (p_ta_hold) else $error("pending lost without ack");
  a_ta_ack: assert property (p_ta_ack) else $error("pending kept after ack");
  a_line2: assert property (p_line2) else $error("line two without its group");
  a_mask3: assert property (p_mask3) else $error("masked line three raised");
  a_rx_low: assert property (p_rx_low) else $error("low mode receive misrouted");
  a_fault: assert property (p_fault) else $error("fault code without its flag");
endmodule : pie_expander_monitor
bind pie_expander pie_expander_monitor mon (.*);

// ---- pie_core_model.sv ----
// Core side model: acknowledges the presented code on its line.
// Assumes line index order follows flag order, so the lowest line holds the winner.
`timescale 1ns/10ps
module pie_core_model (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  // Core pacing
  input  wire logic       i_hold,
  // Block outputs seen by the core
  input  wire logic       i_code_valid,
  input  wire logic [5:0] i_core_lines,
  // Acknowledge back to the block
  output logic            o_ack_valid,
  output logic [2:0]      o_ack_line
);
  logic go;
  function automatic logic [2:0] low_line(input logic [5:0] l);
    low_line = 3'h0;
    for (int n = 5; n >= 0; n--) if (l[n]) low_line = 3'(n);
  endfunction : low_line
  // Hold models a slow core; idle line index toggles so it is never trusted stale
  assign go = i_code_valid && !i_hold && !o_ack_valid;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ack_valid <= 1'b0;
      o_ack_line  <= 3'h7;
    end else begin
      o_ack_valid <= go;
      o_ack_line  <= go ? low_line(i_core_lines) : ~o_ack_line;
    end
  end
endmodule : pie_core_model

// ---- tb.sv ----
// Self-checking bench of the expander with a core model acknowledging codes.
// Assumes the monitor is bound and pie_core_model is compiled.
`timescale 1ns/10ps
module tb;
  logic clk = 0, rst_b = 0, rpin_b = 1, wdog = 0, nmi = 0, lp = 0, hold = 1;
  logic [2:0] pin = 0, ackl;
  logic [10:0] src = 0;
  logic [31:0] en = 0, pend, ackf;
  logic [5:0] mask = 0, lines;
  logic [15:0] code;
  logic ackv, rv, cv, nmo;
  int fails = 0, total_checks = 0, a, c;
  int bitp[16] = '{1, 5, 6, 12, 13, 14, 15, 16, 17, 18, 19, 24, 25, 0, 2, 3};
  logic [15:0] cod[16] = '{16'h0004, 16'h0006, 16'h0007, 16'h0027, 16'h0028, 16'h0029,
    16'h002A, 16'h002B, 16'h002C, 16'h002D, 16'h002E, 16'h0006, 16'h0007, 16'h0020,
    16'h0001, 16'h0011};
  pie_expander uut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_reset_pin_b(rpin_b),
    .i_watchdog_timeout(wdog), .i_power_stage_fault_request(pin[0]),
    .i_external_pin_request_a(pin[1]), .i_external_pin_request_b(pin[2]),
    .i_converter_done_request(src[0]), .i_serial_receive_request(src[1]),
    .i_serial_transmit_request(src[2]), .i_timer_a_period_request(src[3]),
    .i_timer_a_compare_request(src[4]), .i_timer_a_underflow_request(src[5]),
    .i_timer_a_overflow_request(src[6]), .i_timer_b_period_request(src[7]),
    .i_timer_b_compare_request(src[8]), .i_timer_b_underflow_request(src[9]),
    .i_timer_b_overflow_request(src[10]), .i_software_nmi(nmi), .i_source_enable(en),
    .i_core_line_mask(mask), .i_serial_low_priority(lp), .i_ack_line(ackl),
    .i_ack_valid(ackv), .o_reset_vector_line(rv), .o_core_lines(lines), .o_nmi(nmo),
    .o_source_vector_code(code), .o_code_valid(cv), .o_group_pending_flags(pend),
    .o_group_acknowledge_flags(ackf));
  pie_core_model core (.i_sys_clk(clk), .i_rst_b(rst_b), .i_hold(hold), .i_code_valid(cv),
    .i_core_lines(lines), .o_ack_valid(ackv), .o_ack_line(ackl));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  function automatic int line_of(input int b);
    return b < 12 ? 0 : b < 16 ? 1 : b < 24 ? 2 : 4;
  endfunction : line_of
  // Slow core first so the raised state can be seen, then let it acknowledge
  task automatic drain;
    mask = 6'h3F;
    hold = 1'b0;
    for (int n = 0; n < 12 && pend !== 32'h0; n++) @(negedge clk);
    chk(pend, 32'h0);
    chk(lines, 32'h0);
    repeat (4) @(negedge clk);
    hold = 1'b1;
  endtask : drain
  task automatic one(input int k);
    logic e, m;
    lp = (k == 11 || k == 12);
    if (k > 12) pin[k - 13] = 1'b1;
    else src[k > 10 ? k - 10 : k] = 1'b1;
    @(negedge clk);
    src = '0;
    for (int n = 0; n < 8 && pend[bitp[k]] !== 1'b1; n++) @(negedge clk);
    pin = '0;
    e = en[bitp[k]];
    m = e & mask[line_of(bitp[k])];
    chk(pend[bitp[k]], e);
    chk(lines[line_of(bitp[k])], m);
    chk(cv, m);
    if (m) chk(code, cod[k]);
    chk(ackf, e ? 32'h1 << bitp[k] : 32'h0);
    drain();
  endtask : one
  initial begin
    void'($urandom(94646));
    repeat (6) @(negedge clk);
    chk(rv, 1'b1);
    chk(pend, 32'h0);
    chk({nmo, cv, lines}, 32'h0);
    rst_b = 1'b1;
    rpin_b = 1'b0;
    @(negedge clk);
    chk(rv, 1'b1);
    rpin_b = 1'b1;
    wdog = 1'b1;
    @(negedge clk);
    chk(rv, 1'b1);
    wdog = 1'b0;
    @(negedge clk);
    chk(rv, 1'b0);
    nmi = 1'b1;
    @(negedge clk);
    nmi = 1'b0;
    chk(nmo, 1'b1);
    en = '1;
    mask = 6'h3F;
    for (int k = 0; k < 16; k++) one(k);
    repeat (24) begin
      en = $urandom;
      mask = 6'($urandom);
      one($urandom % 16);
    end
    en = '1;
    lp = 1'b0;
    // Reset in mid-run wipes a latched request
    src[3] = 1'b1;
    @(negedge clk);
    src = '0;
    chk(pend, 32'h1 << 12);
    rst_b = 1'b0;
    @(negedge clk);
    chk(pend, 32'h0);
    chk(rv, 1'b1);
    rst_b = 1'b1;
    @(negedge clk);
    repeat (10) begin
      a = $urandom % 11;
      c = $urandom % 11;
      src[a] = 1'b1;
      src[c] = 1'b1;
      @(negedge clk);
      src = '0;
      chk(code, cod[a < c ? a : c]);
      drain();
    end
    results();
  end
  initial begin
    #100000;
    fails++;
    results();
  end
endmodule : tb
